// file: hw/thrf_consts.svh
`ifndef THRF_CONSTS_SVH
`define THRF_CONSTS_SVH
`define THRF_NCOL      4
`define THRF_CW        2
`define THRF_IDW       8
`define THRF_ROWS      256
`define THRF_DELAY     31
`define THRF_LANES     4
`define THRF_LBITS     8
`define THRF_LAST_BIT  3'h7
`define THRF_HDR_DATA  2'h1
`define THRF_HDR_CTRL  2'h2
`define THRF_IDLE_PAY  28'h0000000
`define THRF_ID_ONE    8'h01
`define THRF_ID_STEP   9'h001
`define THRF_FIFO_DEP  2
`endif

// file: hw/thrf_pkg.sv
package thrf_pkg;
   typedef enum logic [1:0] {
      K_IDLE = 2'b00,
      K_HEAD = 2'b01,
      K_DATA = 2'b10,
      K_TAIL = 2'b11
   } thrf_kind_t;
   typedef struct packed {
      thrf_kind_t  kind;
      logic [27:0] pay;
   } thrf_word_t;
   typedef struct packed {
      logic        valid;
      logic        last;
      logic        none;
      logic [5:0]  row;
      logic [3:0]  map;
      logic [15:0] charge_duration_value;
   } thrf_hit_t;
   typedef struct packed {
      logic [7:0]  id;
      logic        last;
      thrf_word_t  w;
   } thrf_bob_t;
   typedef enum logic [2:0] {
      B_IDLE = 3'b000,
      B_HEAD = 3'b001,
      B_BODY = 3'b010,
      B_TAIL = 3'b011,
      B_FREE = 3'b100
   } thrf_bst_t;
endpackage : thrf_pkg

// file: hw/thrf_flow.sv
`timescale 1ns/1ps
`include "thrf_consts.svh"

// ----------------------------------------
// Two-entry buffer
// ----------------------------------------
module thrf_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = `THRF_FIFO_DEP
) (
   input  wire logic         clock_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic          push;
   logic          pop;

   assign in_ready_o  = cnt_q != CW'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o  = mem_q[rp_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end
endmodule : thrf_fifo

module thrf_flow (
   input  wire logic                                 clock_i,
   input  wire logic                                 rst_i,
   input  wire logic                                 trig_i,
   input  wire logic [`THRF_IDW-1:0]                 trig_tag_i,
   input  thrf_pkg::thrf_hit_t [`THRF_NCOL-1:0]      mx_hit_i,
   output logic [`THRF_NCOL-1:0]                     mx_req_o,
   output logic [`THRF_NCOL-1:0][`THRF_IDW-1:0]      mx_id_o,
   output logic                                      mx_trig_o,
   output logic [`THRF_IDW-1:0]                      mx_trig_id_o,
   output logic                                      trig_skip_o,
   output logic [`THRF_LANES-1:0]                    lane_o
);
   import thrf_pkg::*;

   localparam int NC    = `THRF_NCOL;
   localparam int LB    = `THRF_LBITS;
   localparam int DLY_A = `THRF_DELAY;

   // ----------------------------------------
   // Trigger table and release delay
   // ----------------------------------------
   logic [`THRF_IDW-1:0]   tag_q  [`THRF_ROWS];
   logic [`THRF_ROWS-1:0]  used_q;
   logic [`THRF_IDW-1:0]   wp_q;
   // Spare top bit tells a full id ring from an empty one
   logic [`THRF_IDW:0]     rel_q;
   logic [`THRF_IDW:0]     bld_q;
   logic [`THRF_DELAY-1:0] dly_q;
   logic                   trig_ok;
   thrf_bst_t              st_q;

   assign trig_ok = trig_i & ~used_q[wp_q];

   always_ff @(posedge clock_i) begin
      if (trig_ok) begin
         tag_q[wp_q] <= trig_tag_i;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         used_q       <= '0;
         wp_q         <= '0;
         mx_trig_o    <= 1'b0;
         mx_trig_id_o <= '0;
         trig_skip_o  <= 1'b0;
      end else begin
         if (st_q == B_FREE) begin
            used_q[bld_q[`THRF_IDW-1:0]] <= 1'b0;
         end
         if (trig_ok) begin
            used_q[wp_q] <= 1'b1;
            wp_q         <= wp_q + `THRF_ID_ONE;
         end
         mx_trig_o    <= trig_ok;
         mx_trig_id_o <= wp_q;
         trig_skip_o  <= trig_i & used_q[wp_q];
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         dly_q <= '0;
         rel_q <= '0;
      end else begin
         dly_q <= {dly_q[`THRF_DELAY-2:0], trig_ok};
         if (dly_q[`THRF_DELAY-1]) begin
            rel_q <= rel_q + `THRF_ID_STEP;
         end
      end
   end

   trig_store_a: assert property (@(posedge clock_i) disable iff (rst_i)
      trig_ok |=> mx_trig_o && mx_trig_id_o == $past(wp_q) && tag_q[$past(wp_q)] == $past(trig_tag_i))
      else $error("trigger tag not stored");
   fixed_delay_a: assert property (@(posedge clock_i) disable iff (rst_i)
      mx_trig_o |-> ##DLY_A (rel_q != $past(rel_q)))
      else $error("release not at fixed delay");

   // ----------------------------------------
   // Core columns
   // ----------------------------------------
   logic [NC-1:0]  req_q;
   logic [NC-1:0]  enc_v_q;
   logic [NC-1:0]  hm;
   logic [NC-1:0]  done;
   logic [NC-1:0]  pop;
   logic [NC-1:0]  bob_v;
   logic [NC-1:0]  bob_rdy;
   thrf_bob_t      enc_q [NC];
   thrf_bob_t      bob_o [NC];
   logic           ev_rdy;
   logic [`THRF_CW-1:0] sel;

   assign mx_req_o = req_q;

   for (genvar c = 0; c < NC; c++) begin : g_col
      logic [`THRF_IDW:0]   cptr_q;
      logic [`THRF_IDW:0]   cptr_d;
      logic                 take;
      logic                 push;
      logic                 enc_v_d;
      logic                 req_c_q;
      logic                 enc_v_c_q;
      thrf_bob_t            enc_c_q;
      thrf_hit_t            h;

      assign mx_id_o[c] = cptr_q[`THRF_IDW-1:0];
      assign req_q[c]   = req_c_q;
      assign enc_v_q[c] = enc_v_c_q;
      assign enc_q[c]   = enc_c_q;
      assign h          = mx_hit_i[c];
      assign take       = req_q[c] & h.valid;
      assign push       = enc_v_q[c] & bob_rdy[c];

      always_comb begin
         enc_v_d = enc_v_q[c];
         if (take & ~h.none) begin
            enc_v_d = 1'b1;
         end else if (push) begin
            enc_v_d = 1'b0;
         end
         cptr_d = cptr_q;
         if (take & (h.last | h.none)) begin
            cptr_d = cptr_q + `THRF_ID_STEP;
         end
      end

      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            cptr_q    <= '0;
            req_c_q   <= 1'b0;
            enc_v_c_q <= 1'b0;
            enc_c_q   <= '0;
         end else begin
            cptr_q    <= cptr_d;
            req_c_q   <= (cptr_d != rel_q) & ~enc_v_d;
            enc_v_c_q <= enc_v_d;
            if (take & ~h.none) begin
               enc_c_q <= '{id: cptr_q[`THRF_IDW-1:0], last: h.last, w: '{kind: K_DATA,
                              pay: {`THRF_CW'(c), h.row, h.map, h.charge_duration_value & {{4{h.map[3]}}, {4{h.map[2]}},
                                    {4{h.map[1]}}, {4{h.map[0]}}}}}};
            end
         end
      end

      thrf_fifo #(.W($bits(thrf_bob_t))) u_bob (
         .clock_i     (clock_i),
         .rst_i       (rst_i),
         .in_valid_i  (enc_v_q[c]),
         .in_ready_o  (bob_rdy[c]),
         .in_data_i   (enc_q[c]),
         .out_valid_o (bob_v[c]),
         .out_ready_i (pop[c]),
         .out_data_o  (bob_o[c])
      );

      assign hm[c]   = bob_v[c] & (bob_o[c].id == bld_q[`THRF_IDW-1:0]);
      assign done[c] = ~hm[c] & ~(enc_v_q[c] & (enc_q[c].id == bld_q[`THRF_IDW-1:0]))
                       & (cptr_q != bld_q);
      assign pop[c]  = (st_q == B_BODY) & (sel == `THRF_CW'(c)) & hm[c] & ev_rdy;

      col_pause_a: assert property (@(posedge clock_i) disable iff (rst_i)
         (enc_v_q[c] && !bob_rdy[c]) |=> !req_q[c] && enc_v_q[c] && $stable(enc_q[c]))
         else $error("column fetches with full stage");
      col_head_a: assert property (@(posedge clock_i) disable iff (rst_i)
         pop[c] |-> bob_o[c].id == bld_q[`THRF_IDW-1:0] && st_q == B_BODY)
         else $error("column word for wrong trigger");
   end

   // ----------------------------------------
   // Event builder
   // ----------------------------------------
   logic       any;
   logic       ev_v;
   thrf_word_t ev_w;

   always_comb begin
      sel = '0;
      any = 1'b0;
      for (int i = NC - 1; i >= 0; i--) begin
         if (hm[i]) begin
            sel = `THRF_CW'(i);
            any = 1'b1;
         end
      end
   end

   always_comb begin
      ev_v = 1'b0;
      ev_w = '{kind: K_IDLE, pay: `THRF_IDLE_PAY};
      case (st_q)
         B_HEAD: begin
            ev_v = 1'b1;
            ev_w = '{kind: K_HEAD, pay: 28'(tag_q[bld_q[`THRF_IDW-1:0]])};
         end
         B_BODY: begin
            ev_v = any;
            ev_w = bob_o[sel].w;
         end
         B_TAIL: begin
            ev_v = 1'b1;
            ev_w = '{kind: K_TAIL, pay: 28'(tag_q[bld_q[`THRF_IDW-1:0]])};
         end
         default: begin
            ev_v = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_q  <= B_IDLE;
         bld_q <= '0;
      end else begin
         case (st_q)
            B_IDLE: begin
               if (bld_q != rel_q) begin
                  st_q <= B_HEAD;
               end
            end
            B_HEAD: begin
               if (ev_rdy) begin
                  st_q <= B_BODY;
               end
            end
            B_BODY: begin
               if (&done) begin
                  st_q <= B_TAIL;
               end
            end
            B_TAIL: begin
               if (ev_rdy) begin
                  st_q <= B_FREE;
               end
            end
            B_FREE: begin
               bld_q <= bld_q + `THRF_ID_STEP;
               st_q  <= B_IDLE;
            end
            default: begin
               st_q <= B_IDLE;
            end
         endcase
      end
   end

   start_order_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (st_q == B_IDLE && bld_q != rel_q) |=> st_q == B_HEAD ##1 (st_q == B_HEAD || st_q == B_BODY))
      else $error("pending trigger not started");
   tag_free_a: assert property (@(posedge clock_i) disable iff (rst_i)
      st_q == B_FREE |=> !used_q[$past(bld_q[`THRF_IDW-1:0])] && bld_q == $past(bld_q) + `THRF_ID_STEP)
      else $error("tag row not freed");
   stall_full_a: assert property (@(posedge clock_i) disable iff (rst_i)
      !ev_rdy |-> pop == '0 ##1 (($past(st_q) != B_HEAD && $past(st_q) != B_TAIL) || $stable(st_q)))
      else $error("builder advanced into full buffer");

   // ----------------------------------------
   // Event buffer and line encoder
   // ----------------------------------------
   logic                          eo_v;
   logic                          eo_pop;
   thrf_word_t                    eo_w;
   logic [2:0]                    bc_q;
   logic [`THRF_LANES*LB-1:0]     sh_q;
   logic [`THRF_LANES*LB-1:0]     frame;

   assign eo_pop = bc_q == `THRF_LAST_BIT;

   thrf_fifo #(.W($bits(thrf_word_t))) u_evb (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .in_valid_i  (ev_v),
      .in_ready_o  (ev_rdy),
      .in_data_i   (ev_w),
      .out_valid_o (eo_v),
      .out_ready_i (eo_pop),
      .out_data_o  (eo_w)
   );

   always_comb begin
      frame = {`THRF_HDR_CTRL, K_IDLE, `THRF_IDLE_PAY};
      if (eo_v) begin
         frame = {(eo_w.kind == K_DATA) ? `THRF_HDR_DATA : `THRF_HDR_CTRL, eo_w};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         bc_q   <= '0;
         sh_q   <= '0;
         lane_o <= '0;
      end else begin
         bc_q <= bc_q + 3'h1;
         for (int l = 0; l < `THRF_LANES; l++) begin
            lane_o[l] <= sh_q[l*LB + LB - 1];
            if (eo_pop) begin
               sh_q[l*LB +: LB] <= frame[l*LB +: LB];
            end else begin
               sh_q[l*LB +: LB] <= {sh_q[l*LB +: LB-1], 1'b0};
            end
         end
      end
   end

   idle_fill_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (eo_pop && !eo_v) |=> sh_q == {`THRF_HDR_CTRL, K_IDLE, `THRF_IDLE_PAY} ##1 lane_o == 4'h8)
      else $error("idle frame not sent");
endmodule : thrf_flow

// file: bench/thrf_daq_model.sv
`timescale 1ns/1ps
`include "thrf_consts.svh"

// ----------------------------------------
// Lane receiver of the acquisition side
// ----------------------------------------
module thrf_daq_model (
   input  wire logic                   clock_i,
   input  wire logic                   rst_i,
   input  wire logic [`THRF_LANES-1:0] lane_i,
   output logic                        frame_v_o,
   output logic [31:0]                 frame_o
);
   logic [2:0]  n_q;
   logic        lk_q;
   logic [31:0] sh_q;
   logic [31:0] nx;

   // Each lane carries one byte of the frame, MSB first
   always_comb begin
      for (int l = 0; l < `THRF_LANES; l++) begin
         nx[l*8+:8] = {sh_q[l*8+:7], lane_i[l]};
      end
   end

   // Lock on the first set bit, which opens the first idle frame
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         n_q       <= 3'h0;
         lk_q      <= 1'b0;
         sh_q      <= 32'h0;
         frame_v_o <= 1'b0;
         frame_o   <= 32'h0;
      end else begin
         frame_v_o <= 1'b0;
         if (lk_q || lane_i[3]) begin
            lk_q <= 1'b1;
            sh_q <= nx;
            n_q  <= n_q + 3'h1;
            if (n_q == `THRF_LAST_BIT) begin
               frame_v_o <= 1'b1;
               frame_o   <= nx;
            end
         end
      end
   end
endmodule : thrf_daq_model

// file: bench/triggered_hit_readout_flow_tb.sv
`timescale 1ns/1ps
`include "thrf_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module triggered_hit_readout_flow_tb;
   import thrf_pkg::*;
   logic            clock_i = 1'b0;
   logic            rst_i = 1'b1;
   logic            trig_i = 1'b0;
   logic [7:0]      trig_tag_i = 8'h00;
   thrf_hit_t [3:0] hit_q = '0;
   logic [3:0]      mx_req_o;
   logic [3:0][7:0] mx_id_o;
   logic            mx_trig_o;
   logic [7:0]      mx_trig_id_o;
   logic            trig_skip_o;
   logic [3:0]      lane_o;
   logic            frame_v;
   logic [31:0]     frame;
   logic [7:0]      r = 8'h4c;
   logic            tp = 1'b0;
   logic            tps = 1'b0;
   logic            exp_skip = 1'b0;
   logic            stall = 1'b0;
   logic            tk;
   logic [7:0]      id8;
   logic [1:0]      c2;
   logic [7:0]      tagt [256];
   logic [5:0]      rowt [256][4][3];
   logic [3:0]      mapt [256][4][3];
   logic [15:0]     tott [256][4][3];
   bit              seen [256];
   int              nh [256][4];
   int              trig_cyc [256];
   int              ptr [4];
   int              cnt [4];
   logic [7:0]      cid [4];
   int              bad_count = 0;
   int              checked = 0;
   int              cyc = 0;
   int              ev = 0;
   int              exp_wp = 0;
   int              drv_id = 0;

   always #5 clock_i = ~clock_i;

   thrf_flow dut_u (.clock_i(clock_i), .rst_i(rst_i), .trig_i(trig_i), .trig_tag_i(trig_tag_i),
      .mx_hit_i(hit_q), .mx_req_o(mx_req_o), .mx_id_o(mx_id_o), .mx_trig_o(mx_trig_o),
      .mx_trig_id_o(mx_trig_id_o), .trig_skip_o(trig_skip_o), .lane_o(lane_o));

   thrf_daq_model daq_u (.clock_i(clock_i), .rst_i(rst_i), .lane_i(lane_o), .frame_v_o(frame_v),
      .frame_o(frame));

   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   function automatic logic [7:0] nxt();
      r = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
      return r;
   endfunction : nxt

   function automatic logic [27:0] enc(logic [7:0] id, int c, int k);
      logic [15:0] m;
      for (int i = 0; i < 4; i++) m[i*4+:4] = {4{mapt[id][c][k][i]}};
      return {2'(c), rowt[id][c][k], mapt[id][c][k], tott[id][c][k] & m};
   endfunction : enc

   function automatic thrf_hit_t mk(logic [7:0] id, int c, int k, logic v);
      thrf_hit_t h;
      h.valid = v;
      h.none = (nh[id][c] == 0);
      h.last = (k == nh[id][c] - 1);
      h.row = rowt[id][c][k];
      h.map = mapt[id][c][k];
      h.charge_duration_value = tott[id][c][k];
      return h;
   endfunction : mk

   // ----------------------------------------
   // Pixel matrix answer per column
   // ----------------------------------------
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         hit_q <= '0;
         for (int c = 0; c < 4; c++) begin
            cnt[c] = 0;
            cid[c] = 8'h00;
         end
      end else begin
         for (int c = 0; c < 4; c++) begin
            tk = mx_req_o[c] && hit_q[c].valid;
            if (tk) begin
               `CHK(mx_id_o[c], cid[c])
               `CHK((cyc >= trig_cyc[cid[c]] + 32), 1'b1)
               if (hit_q[c].none || hit_q[c].last) begin
                  cnt[c] = 0;
                  cid[c] = cid[c] + 8'h01;
               end else begin
                  cnt[c] = cnt[c] + 1;
               end
            end
            hit_q[c] <= mk(cid[c], c, cnt[c], (hit_q[c].valid && !tk) || (!stall && seen[cid[c]]));
         end
      end
   end

   // ----------------------------------------
   // Trigger answer and frame monitors
   // ----------------------------------------
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (!rst_i) begin
         if (tps) `CHK({mx_trig_o, trig_skip_o}, 2'b01)
         else if (tp) begin
            `CHK({mx_trig_o, trig_skip_o, mx_trig_id_o}, {2'b10, 8'(exp_wp)})
            exp_wp = exp_wp + 1;
         end else `CHK({mx_trig_o, trig_skip_o}, 2'b00)
         if (trig_i && !exp_skip) trig_cyc[exp_wp % 256] = cyc;
         tp  <= trig_i && !exp_skip;
         tps <= trig_i && exp_skip;
      end
      if (frame_v) begin
         id8 = 8'(ev);
         c2 = frame[27:26];
         case (frame[29:28])
            K_IDLE: `CHK(frame, {`THRF_HDR_CTRL, K_IDLE, `THRF_IDLE_PAY})
            K_HEAD: begin
               `CHK(frame, {`THRF_HDR_CTRL, K_HEAD, 20'h0, tagt[id8]})
               for (int c = 0; c < 4; c++) ptr[c] = 0;
            end
            K_DATA: begin
               `CHK(frame, {`THRF_HDR_DATA, K_DATA, enc(id8, c2, ptr[c2])})
               ptr[c2] = ptr[c2] + 1;
            end
            default: begin
               `CHK(frame, {`THRF_HDR_CTRL, K_TAIL, 20'h0, tagt[id8]})
               for (int c = 0; c < 4; c++) `CHK((ptr[c] == nh[id8][c]), 1'b1)
               ev = ev + 1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Stimulus tasks
   // ----------------------------------------
   task automatic trig(logic [7:0] tag, int gap, logic sk);
      @(posedge clock_i);
      trig_i <= 1'b1;
      trig_tag_i <= tag;
      exp_skip <= sk;
      if (!sk) begin
         tagt[drv_id % 256] = tag;
         seen[drv_id % 256] = 1'b1;
         drv_id++;
      end
      if (gap > 0) begin
         @(posedge clock_i);
         trig_i <= 1'b0;
         exp_skip <= 1'b0;
         repeat (gap - 1) @(posedge clock_i);
      end
   endtask : trig

   task automatic wait_ev(int n);
      int k;
      k = 0;
      while (ev < n && k < 40000) begin
         @(posedge clock_i);
         k++;
      end
      `CHK(ev, n)
   endtask : wait_ev

   task automatic close_out();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out

   initial begin
      repeat (80000) @(posedge clock_i);
      bad_count++;
      close_out();
   end

   initial begin
      for (int i = 0; i < 256; i++) begin
         for (int c = 0; c < 4; c++) begin
            nh[i][c] = nxt() % 4;
            for (int k = 0; k < 3; k++) begin
               rowt[i][c][k] = 6'(nxt());
               mapt[i][c][k] = 4'(nxt());
               tott[i][c][k] = {nxt(), nxt()};
            end
         end
      end
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 20; i++) trig(nxt(), (i == 0) ? 0 : ((i == 19) ? 1 : nxt() % 4), 1'b0);
      wait_ev(20);
      stall <= 1'b1;
      repeat (2) @(posedge clock_i);
      for (int i = 0; i < 256; i++) trig(nxt(), 0, 1'b0);
      trig(nxt(), 1, 1'b1);
      repeat (100) @(posedge clock_i);
      `CHK(ev, 20)
      stall <= 1'b0;
      wait_ev(276);
      repeat (64) @(posedge clock_i);
      close_out();
   end
endmodule : triggered_hit_readout_flow_tb
